// ===== include/pt8_pkg.sv
package pt8_pkg;

    // ---------------------------------------------------------------
    // register word indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [2:0] PT8_IDX_COUNT  = 3'h0;
    localparam logic [2:0] PT8_IDX_PERIOD = 3'h1;
    localparam logic [2:0] PT8_IDX_CTRL   = 3'h2;
    localparam logic [2:0] PT8_IDX_STATUS = 3'h3;
    localparam logic [2:0] PT8_IDX_MASK   = 3'h4;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int PT8_CTL_PRE_LSB  = 0;
    localparam int PT8_CTL_ON_BIT   = 2;
    localparam int PT8_CTL_POST_LSB = 3;
    localparam int PT8_CTL_W        = 7;
    localparam int PT8_STAT_BIT     = 0;

    // ---------------------------------------------------------------
    // reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] PT8_COUNT_RST  = 8'h00;
    localparam logic [7:0] PT8_PERIOD_RST = 8'hFF;
    localparam logic [6:0] PT8_CTRL_RST   = 7'h00;
    localparam logic [1:0] PT8_PH_LAST    = 2'h3;
    localparam logic [5:0] PT8_PRE_TC1    = 6'h00;
    localparam logic [5:0] PT8_PRE_TC4    = 6'h03;
    localparam logic [5:0] PT8_PRE_TC16   = 6'h0F;
    localparam logic [5:0] PT8_PRE_TC64   = 6'h3F;

    // ---------------------------------------------------------------
    // bus states, gray along the path
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        PT8_BUS_IDLE = 1'b0,
        PT8_BUS_ACK  = 1'b1
    } pt8_bus_t;

    // all state of the timer
    typedef struct packed {
        pt8_bus_t   bus;
        logic       wait_r;
        logic [7:0] rdata;
        logic [1:0] ph;
        logic [5:0] pre;
        logic [3:0] post;
        logic [7:0] cnt;
        logic [7:0] per;
        logic [6:0] ctl;
        logic       flag;
        logic       ien;
        logic       match;
        logic       shift;
        logic       irq;
    } pt8_state_t;

endpackage

// ===== verilog/pt8_timer.sv
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - the count advances from the instruction clock, a quarter of clk, after the prescaler.
// - the 8-bit count steps by one from zero on each prescaled tick while switched on.
// - the prescaler divides by 1, 4, 16 or 64 for select codes 00, 01, 10, 11.
// - count and period are compared each tick and equality makes the match pulse.
// - after a match the count goes to zero and the postscaler advances.
// - software reads and writes count and period at any time.
// - reset clears the count and sets the period to all ones.
// - prescaler and postscaler clear on a count write, a control write and reset.
// - match pulses feed a 4-bit postscaler whose terminal count sets the flag.
// - the flag stays set and raises the interrupt only when enabled.
// - the postscale code selects a ratio of code plus one, 1:1 to 1:16.
// - control holds postscale in 6-3, on in 2, prescale in 1-0, bit 7 reads zero.
// - the unscaled match pulse goes out as the pwm time base.
// - the match output serves the serial port as its spi shift clock source.
// - nothing counts while the processor sleeps.
// - count and period keep their values during sleep.
module pt8_timer
    import pt8_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // processor sleep level, same clock domain
    input  wire logic        sleep,
    // avalon-mm slave
    input  wire logic [2:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // timer outputs
    output logic             match_pulse,
    output logic             spi_shift_clk,
    output logic             irq
);

    // ---------------------------------------------------------------
    // state and decode
    // ---------------------------------------------------------------
    pt8_state_t st_reg;
    pt8_state_t st_next;
    pt8_state_t st_rst;

    logic       acc;
    logic       wr;
    logic       wr_cnt;
    logic       wr_per;
    logic       wr_ctl;
    logic       wr_stat;
    logic       wr_mask;
    logic       on;
    logic       run;
    logic       inst_tick;
    logic [5:0] pre_tc;
    logic       tick;
    logic       match_ev;
    logic       post_tc;
    logic [7:0] rd_val;

    // reset image of the state
    always_comb
    begin
        st_rst        = '0;
        st_rst.bus    = PT8_BUS_IDLE;
        st_rst.wait_r = 1'b1;
        st_rst.cnt    = PT8_COUNT_RST;
        st_rst.per    = PT8_PERIOD_RST;
        st_rst.ctl    = PT8_CTRL_RST;
    end

    // bus access is taken in the ack state, request still held
    assign acc     = (st_reg.bus == PT8_BUS_ACK) && (read || write);
    assign wr      = acc && write && byteenable[0];
    assign wr_cnt  = wr && (address == PT8_IDX_COUNT);
    assign wr_per  = wr && (address == PT8_IDX_PERIOD);
    assign wr_ctl  = wr && (address == PT8_IDX_CTRL);
    assign wr_stat = wr && (address == PT8_IDX_STATUS);
    assign wr_mask = wr && (address == PT8_IDX_MASK);

    // ---------------------------------------------------------------
    // clock chain
    // ---------------------------------------------------------------
    assign on        = st_reg.ctl[PT8_CTL_ON_BIT];
    assign run       = on && !sleep;
    assign inst_tick = run && (st_reg.ph == PT8_PH_LAST);

    // prescaler terminal value per select code
    always_comb
    begin
        case (st_reg.ctl[PT8_CTL_PRE_LSB +: 2])
            2'h0:    pre_tc = PT8_PRE_TC1;
            2'h1:    pre_tc = PT8_PRE_TC4;
            2'h2:    pre_tc = PT8_PRE_TC16;
            default: pre_tc = PT8_PRE_TC64;
        endcase
    end

    // prescaled tick, period compare and postscaler terminal count
    assign tick     = inst_tick && (st_reg.pre == pre_tc);
    assign match_ev = tick && (st_reg.cnt == st_reg.per) && !wr_cnt;
    assign post_tc  = st_reg.post == st_reg.ctl[PT8_CTL_POST_LSB +: 4];

    // read mux, unimplemented bits read zero
    always_comb
    begin
        case (address)
            PT8_IDX_COUNT:  rd_val = st_reg.cnt;
            PT8_IDX_PERIOD: rd_val = st_reg.per;
            PT8_IDX_CTRL:   rd_val = {1'b0, st_reg.ctl};
            PT8_IDX_STATUS: rd_val = {7'h00, st_reg.flag};
            PT8_IDX_MASK:   rd_val = {7'h00, st_reg.ien};
            default:        rd_val = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;

        // two-step handshake: ack cycle, then idle
        case (st_reg.bus)
            PT8_BUS_IDLE:
            begin
                if (read || write)
                begin
                    st_next.bus    = PT8_BUS_ACK;
                    st_next.wait_r = 1'b0;
                    st_next.rdata  = rd_val;
                end
            end
            PT8_BUS_ACK:
            begin
                st_next.bus    = PT8_BUS_IDLE;
                st_next.wait_r = 1'b1;
            end
            default:
            begin
                st_next.bus    = PT8_BUS_IDLE;
                st_next.wait_r = 1'b1;
            end
        endcase

        // instruction phase stops with the clock in sleep
        if (run)
        begin
            st_next.ph = st_reg.ph + 2'h1;
        end

        // prescaler, held while off
        if (inst_tick)
        begin
            st_next.pre = (st_reg.pre == pre_tc) ? 6'h00 : st_reg.pre + 6'h01;
        end

        // counter step and wrap
        if (tick)
        begin
            if (st_reg.cnt == st_reg.per)
            begin
                st_next.cnt = PT8_COUNT_RST;
            end
            else
            begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
        end

        // postscaler: ratio is code plus one
        if (match_ev)
        begin
            st_next.post = post_tc ? 4'h0 : st_reg.post + 4'h1;
        end

        // unscaled pulse and serial clock toggle
        st_next.match = match_ev;
        if (match_ev)
        begin
            st_next.shift = !st_reg.shift;
        end

        // register writes
        if (wr_cnt)
        begin
            st_next.cnt = writedata[7:0];
        end
        if (wr_per)
        begin
            st_next.per = writedata[7:0];
        end
        if (wr_ctl)
        begin
            st_next.ctl = writedata[PT8_CTL_W-1:0];
        end
        if (wr_mask)
        begin
            st_next.ien = writedata[PT8_STAT_BIT];
        end
        if (wr_cnt || wr_ctl)
        begin
            st_next.pre  = 6'h00;
            st_next.post = 4'h0;
        end

        // sticky flag, set wins over write-one clear
        if (wr_stat && writedata[PT8_STAT_BIT])
        begin
            st_next.flag = 1'b0;
        end
        if (match_ev && post_tc)
        begin
            st_next.flag = 1'b1;
        end

        st_next.irq = st_reg.flag && st_reg.ien;
    end

    // state register, frozen while ce is low except that sys_rst still loads the reset image
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= st_rst;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state
    assign readdata      = {24'h000000, st_reg.rdata};
    assign waitrequest   = st_reg.wait_r;
    assign match_pulse   = st_reg.match;
    assign spi_shift_clk = st_reg.shift;
    assign irq           = st_reg.irq;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_inst_quarter: assert property (ce && inst_tick |=> !inst_tick)
        else $error("instruction tick faster than a quarter of clk");

    a_count_step: assert property (
        ce && tick && (st_reg.cnt != st_reg.per) && !wr_cnt
        |=> st_reg.cnt == $past(st_reg.cnt) + 8'h01)
        else $error("count did not step by one");

    a_pre_divide: assert property (ce && tick && !wr_ctl
        |=> st_reg.pre == 6'h00)
        else $error("prescaler not restarted on tick");

    a_match_out: assert property (ce && match_ev |=> match_pulse)
        else $error("match pulse missing");

    a_count_wrap: assert property (ce && match_ev
        |=> st_reg.cnt == 8'h00)
        else $error("count not zero after match");

    a_count_write: assert property (ce && wr_cnt
        |=> st_reg.cnt == $past(writedata[7:0]))
        else $error("count write lost");

    a_reset_vals: assert property (disable iff (1'b0)
        sys_rst |=> st_reg.cnt == PT8_COUNT_RST && st_reg.per == PT8_PERIOD_RST)
        else $error("reset values wrong");

    a_scaler_clear: assert property (ce && (wr_cnt || wr_ctl)
        |=> st_reg.pre == 6'h00 && st_reg.post == 4'h0)
        else $error("scalers not cleared by write");

    a_flag_set: assert property (ce && match_ev && post_tc
        |=> st_reg.flag)
        else $error("flag not set at terminal count");

    a_irq_gate: assert property (ce ##1 ce
        |-> irq == $past(st_reg.flag && st_reg.ien))
        else $error("interrupt not gated by enable");

    a_ctl_read: assert property (!waitrequest
        && $past(address) == PT8_IDX_CTRL |-> readdata[7] == 1'b0)
        else $error("control bit 7 read as one");

    a_shift_tgl: assert property (ce && match_ev
        |=> spi_shift_clk != $past(spi_shift_clk))
        else $error("shift clock did not toggle");

    a_sleep_hold: assert property (ce && sleep && !wr
        |=> $stable(st_reg.cnt) && $stable(st_reg.per) && !match_pulse)
        else $error("count moved in sleep");

    a_off_hold: assert property (ce && !on && !wr
        |=> $stable(st_reg.cnt) && $stable(st_reg.pre) && $stable(st_reg.post))
        else $error("timer moved while off");

    a_off_nomatch: assert property (ce && !run |=> !match_pulse)
        else $error("match pulse while stopped");

    a_post_step: assert property (ce && match_ev && !post_tc && !wr_ctl
        |=> st_reg.post == $past(st_reg.post) + 4'h1)
        else $error("postscaler did not advance");

    a_post_wrap: assert property (ce && match_ev && post_tc && !wr_ctl
        |=> st_reg.post == 4'h0)
        else $error("postscaler did not wrap");

    a_wait_one: assert property (ce && !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_pulse_single: assert property (ce && match_pulse |=> !match_pulse)
        else $error("match pulse longer than one cycle");

    a_per_write: assert property (ce && wr_per
        |=> st_reg.per == $past(writedata[7:0]))
        else $error("period write lost");

    a_flag_sticky: assert property (ce && st_reg.flag && !wr_stat
        |=> st_reg.flag)
        else $error("flag dropped without a clear");

    // ---------------------------------------------------------------
    // cover points for the main scenarios
    // ---------------------------------------------------------------
    c_match: cover property (ce && match_ev);
    c_flag_div: cover property (ce && match_ev && post_tc && st_reg.ctl[6:3] != 4'h0);
    c_set_clear: cover property (ce && wr_stat && match_ev && post_tc);
    c_read_ack: cover property (read && !waitrequest);
    c_sleep_freeze: cover property (ce && sleep && on && !wr);

endmodule

// ===== testbench/pt8_far_model.sv
`timescale 1ns/100ps

module pt8_far_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // timer outputs seen by the pwm unit and the serial port
    input  wire logic        match_pulse,
    input  wire logic        spi_shift_clk,
    // observations for the bench
    output logic      [15:0] match_cnt,
    output logic      [15:0] last_gap,
    output logic      [15:0] toggle_cnt
);
    logic [15:0] cyc;
    logic [15:0] last_at;
    logic        spi_q;

    // time base consumer: counts matches, spacing and shift clock edges
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cyc        <= 16'h0000;
            last_at    <= 16'h0000;
            match_cnt  <= 16'h0000;
            last_gap   <= 16'h0000;
            toggle_cnt <= 16'h0000;
            spi_q      <= 1'b0;
        end
        else
        begin
            cyc   <= cyc + 16'h0001;
            spi_q <= spi_shift_clk;
            if (match_pulse === 1'b1)
            begin
                match_cnt <= match_cnt + 16'h0001;
                last_gap  <= cyc - last_at;
                last_at   <= cyc;
            end
            if (spi_shift_clk !== spi_q)
                toggle_cnt <= toggle_cnt + 16'h0001;
        end
    end
endmodule

// ===== testbench/period_timer_8bit_test.sv
`timescale 1ns/100ps

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h want %h", $time, (got), (exp)); end end

module period_timer_8bit_test
    import pt8_pkg::*;
;
    logic        clk, sys_rst, ce, sleep, read, write;
    logic [2:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata, rd, rd0;
    logic        waitrequest, match_pulse, spi_shift_clk, irq;
    logic [15:0] match_cnt, last_gap, toggle_cnt, m0;
    int          error_cnt, tests_run;
    int          n_tab [4] = '{1, 4, 16, 64};

    pt8_timer i_pt8_timer (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sleep(sleep),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .match_pulse(match_pulse), .spi_shift_clk(spi_shift_clk), .irq(irq));

    pt8_far_model i_pt8_far_model (.clk(clk), .sys_rst(sys_rst),
        .match_pulse(match_pulse), .spi_shift_clk(spi_shift_clk),
        .match_cnt(match_cnt), .last_gap(last_gap), .toggle_cnt(toggle_cnt));

    // 50 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // verdict and end of run
    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int g;
        g = 0;
        @(posedge clk);
        address   <= a;
        writedata <= {24'h000000, d};
        write     <= wr;
        read      <= ~wr;
        do
        begin
            @(posedge clk);
            g++;
        end
        while (waitrequest !== 1'b0 && g < 50);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (g >= 50)
            error_cnt++;
    endtask

    // wait until the far side has seen a number of matches
    task automatic wait_m(input logic [15:0] n);
        int g;
        g = 0;
        while (match_cnt < n && g < 20000)
        begin
            @(posedge clk);
            g++;
        end
        if (g >= 20000)
            error_cnt++;
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    // main sequence
    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        sys_rst = 1'b1; ce = 1'b1; sleep = 1'b0; read = 1'b0; write = 1'b0;
        address = 3'h0; byteenable = 4'hF; writedata = 32'h00000000;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values and register map
        bus(1'b0, PT8_IDX_COUNT, 8'h00);  `CHK(rd, 32'h00000000)
        bus(1'b0, PT8_IDX_PERIOD, 8'h00); `CHK(rd, 32'h000000FF)
        bus(1'b0, PT8_IDX_CTRL, 8'h00);   `CHK(rd, 32'h00000000)
        bus(1'b0, 3'h5, 8'h00);           `CHK(rd, 32'h00000000)
        bus(1'b1, PT8_IDX_CTRL, 8'hFF);
        bus(1'b0, PT8_IDX_CTRL, 8'h00);   `CHK(rd, 32'h0000007F)
        bus(1'b1, PT8_IDX_CTRL, 8'h00);
        bus(1'b1, PT8_IDX_PERIOD, 8'hA5);
        bus(1'b1, PT8_IDX_COUNT, 8'h5A);
        bus(1'b0, PT8_IDX_PERIOD, 8'h00); `CHK(rd, 32'h000000A5)
        bus(1'b0, PT8_IDX_COUNT, 8'h00);  `CHK(rd, 32'h0000005A)
        byteenable <= 4'h0;
        bus(1'b1, PT8_IDX_PERIOD, 8'h11);
        byteenable <= 4'hF;
        bus(1'b0, PT8_IDX_PERIOD, 8'h00); `CHK(rd, 32'h000000A5)
        // match spacing for every prescale code, period 3
        bus(1'b1, PT8_IDX_PERIOD, 8'h03);
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, PT8_IDX_COUNT, 8'h00);
            bus(1'b1, PT8_IDX_CTRL, {6'b000001, c[1:0]});
            m0 = match_cnt;
            wait_m(m0 + 16'h0003);
            `CHK(last_gap, 16'(4 * n_tab[c] * 4))
        end
        // postscaler ratios, period 7, prescale 1:1
        bus(1'b1, PT8_IDX_PERIOD, 8'h07);
        foreach (n_tab[i])
        begin
            automatic logic [3:0] k = (i == 3) ? 4'hF : 4'(i * 2);
            bus(1'b1, PT8_IDX_CTRL, 8'h00);
            bus(1'b1, PT8_IDX_COUNT, 8'h00);
            bus(1'b1, PT8_IDX_STATUS, 8'h01);
            bus(1'b1, PT8_IDX_CTRL, {1'b0, k, 3'b100});
            m0 = match_cnt;
            wait_m(m0 + 16'(k));
            bus(1'b0, PT8_IDX_STATUS, 8'h00); `CHK(rd[0], 1'b0)
            wait_m(m0 + 16'(k) + 16'h0001);
            repeat (3) @(posedge clk);
            bus(1'b0, PT8_IDX_STATUS, 8'h00); `CHK(rd[0], 1'b1)
        end
        // interrupt masked, unmasked, latched, cleared
        `CHK(irq, 1'b0)
        bus(1'b1, PT8_IDX_MASK, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        bus(1'b1, PT8_IDX_CTRL, 8'h00);
        // let a match launched with the off write reach the far side
        repeat (2) @(posedge clk);
        m0 = match_cnt;
        bus(1'b0, PT8_IDX_COUNT, 8'h00);
        rd0 = rd;
        repeat (300) @(posedge clk);
        bus(1'b0, PT8_IDX_STATUS, 8'h00); `CHK(rd[0], 1'b1)
        `CHK(match_cnt, m0)
        bus(1'b0, PT8_IDX_COUNT, 8'h00);  `CHK(rd, rd0)
        `CHK(toggle_cnt, match_cnt)
        bus(1'b1, PT8_IDX_STATUS, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        // sleep freezes count and period
        bus(1'b1, PT8_IDX_PERIOD, 8'h14);
        bus(1'b1, PT8_IDX_CTRL, 8'h04);
        repeat (37) @(posedge clk);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        m0 = match_cnt;
        bus(1'b0, PT8_IDX_COUNT, 8'h00);
        rd0 = rd;
        repeat (400) @(posedge clk);
        bus(1'b0, PT8_IDX_COUNT, 8'h00);  `CHK(rd, rd0)
        bus(1'b0, PT8_IDX_PERIOD, 8'h00); `CHK(rd, 32'h00000014)
        `CHK(match_cnt, m0)
        sleep <= 1'b0;
        final_report();
    end
endmodule
